/* src/gpio_port_regs.svh */
// Register offsets, field positions, reset values and widths of the eight-pin port.
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// Byte offsets in the device-control memory window.
`define WIN_REVISION_OFFSET   8'h00
`define WIN_DIRECTION_OFFSET  8'h40
`define WIN_LEVEL_OFFSET      8'h42

// Byte offsets of the aliases in configuration space.
`define CFG_DIRECTION_OFFSET  8'hB4
`define CFG_LEVEL_OFFSET      8'hB6

// Register and field geometry.
`define PORT_PIN_COUNT        8
`define REG_DATA_WIDTH        16
`define REG_ADDR_WIDTH        8
`define REG_BE_WIDTH          2
`define SERIAL_CLOCK_PIN      4
`define SERIAL_DATA_PIN       5

// Reset values applied by the fundamental reset, and the value read back from reserved bytes.
`define DIRECTION_RESET       8'h00
`define LEVEL_RESET           8'h00
`define RESERVED_BYTE         8'h00

`endif

/* src/gpio_port_pkg.sv */
// Types shared by the port logic and whoever connects to it.
package gpio_port_pkg;

    // One register request, taken in the cycle that valid is high.
    typedef struct packed {
        logic        valid;      // Request present this cycle.
        logic        write;      // One for write, zero for read.
        logic        cfg_space;  // One selects configuration space, zero the memory window.
        logic [7:0]  addr;       // Byte offset, even.
        logic [15:0] wdata;      // Write data.
        logic [1:0]  be;         // Byte enables, bit 0 for the low byte.
    } reg_req_s;

    // Answer to a request, one cycle after it was taken.
    typedef struct packed {
        logic        ack;        // One-cycle pulse.
        logic [15:0] rdata;      // Read data, zero for writes and unmapped offsets.
    } reg_rsp_s;

    // Controls from the serial-bus controller that may own pins 4 and 5.
    typedef struct packed {
        logic enable;            // Secondary function enabled.
        logic clock_out;         // Level for the clock pin.
        logic clock_oe;          // Drive enable for the clock pin.
        logic data_out;          // Level for the data pin.
        logic data_oe;           // Drive enable for the data pin.
    } serial_ctl_s;

endpackage

/* src/pin_sampler.sv */
// Three-stage synchroniser that accepts a new level once the last two stages agree.
`timescale 1ns/1ns

module pin_sampler #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] stage1_q;  // Metastability catcher, read only by stage2.
    logic [WIDTH-1:0] stage2_q;  // Second stage.
    logic [WIDTH-1:0] stage3_q;  // Third stage, compared with the second.

    // Shift the pins in; a bit changes only when stages two and three agree, filtering one-cycle glitches.
    always_ff @(posedge clock) begin
        if (srst) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
            level_q  <= '0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q  <= (stage2_q & stage3_q) | (level_q & (stage2_q ^ stage3_q)) | (level_q & stage2_q & stage3_q);
        end
    end

endmodule

/* src/gpio_port.sv */
// Eight-pin general-purpose port with direction, level and revision registers.
`timescale 1ns/1ns
`include "gpio_port_regs.svh"

module gpio_port
    import gpio_port_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'hA5  // Arbitrary value, set per silicon revision.
) (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          fundamental_reset,
    input  wire reg_req_s                      req,
    output reg_rsp_s                           rsp_q,
    input  wire serial_ctl_s                   serial_ctl,
    input  wire logic [`PORT_PIN_COUNT-1:0]    pin_in,
    output logic      [`PORT_PIN_COUNT-1:0]    pin_out_q,
    output logic      [`PORT_PIN_COUNT-1:0]    pin_oe_q,
    output logic      [`PORT_PIN_COUNT-1:0]    pin_sampled
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage and sampled pins.

    logic [`PORT_PIN_COUNT-1:0] direction_q;  // One bit per pin, one means output.
    logic [`PORT_PIN_COUNT-1:0] level_q;      // Levels written for output pins.
    logic [`PORT_PIN_COUNT-1:0] direction_d;  // Next direction.
    logic [`PORT_PIN_COUNT-1:0] level_d;      // Next stored level.

    // Pins are asynchronous to this clock, so they pass the filtered synchroniser.
    pin_sampler #(
        .WIDTH    (`PORT_PIN_COUNT)
    ) u_sampler (
        .clock    (clock),
        .srst     (srst),
        .async_in (pin_in),
        .level_q  (pin_sampled)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; both spaces reach the same storage.

    wire taken        = req.valid & ~srst;
    wire hit_revision = ~req.cfg_space & (req.addr == `WIN_REVISION_OFFSET);
    wire hit_dir      = req.cfg_space ? (req.addr == `CFG_DIRECTION_OFFSET)
                                      : (req.addr == `WIN_DIRECTION_OFFSET);
    wire hit_level    = req.cfg_space ? (req.addr == `CFG_LEVEL_OFFSET)
                                      : (req.addr == `WIN_LEVEL_OFFSET);
    wire low_write    = taken & req.write & req.be[0];

    // Mask of pins currently owned by the serial-bus function.
    wire [`PORT_PIN_COUNT-1:0] secondary_mask =
        serial_ctl.enable ? ((8'h01 << `SERIAL_CLOCK_PIN) | (8'h01 << `SERIAL_DATA_PIN)) : 8'h00;

    // Pins whose level register bit is writable and drives the pin.
    wire [`PORT_PIN_COUNT-1:0] gpio_out_mask = direction_q & ~secondary_mask;

    // Only the low byte is stored; the upper byte of both registers is reserved.
    assign direction_d = (low_write & hit_dir) ? req.wdata[7:0] : direction_q;
    // Bits of input or secondary pins keep their old value.
    assign level_d = (low_write & hit_level)
                   ? ((req.wdata[7:0] & gpio_out_mask) | (level_q & ~gpio_out_mask))
                   : level_q;

    // Read view of the level register: stored level on output pins, sampled pin elsewhere.
    wire [`PORT_PIN_COUNT-1:0] level_view =
        (level_q & gpio_out_mask) | (pin_sampled & ~gpio_out_mask);

    wire [15:0] read_mux =
        (req.write)   ? 16'h0000 :
        hit_dir       ? {`RESERVED_BYTE, direction_q} :
        hit_level     ? {`RESERVED_BYTE, level_view} :
        hit_revision  ? {REVISION, `RESERVED_BYTE} :
                        16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Storage: survives srst, cleared only by the fundamental reset.

    // Ordinary resets must not disturb pin state, so srst is deliberately absent here.
    always_ff @(posedge clock) begin
        if (fundamental_reset) begin
            direction_q <= `DIRECTION_RESET;
            level_q     <= `LEVEL_RESET;
        end else begin
            direction_q <= direction_d;
            level_q     <= level_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered so the pads see clean edges.

    // The serial function takes pins 4 and 5 regardless of direction.
    wire [`PORT_PIN_COUNT-1:0] serial_oe =
        ({7'h00, serial_ctl.clock_oe} << `SERIAL_CLOCK_PIN) | ({7'h00, serial_ctl.data_oe} << `SERIAL_DATA_PIN);
    wire [`PORT_PIN_COUNT-1:0] serial_out =
        ({7'h00, serial_ctl.clock_out} << `SERIAL_CLOCK_PIN) | ({7'h00, serial_ctl.data_out} << `SERIAL_DATA_PIN);

    always_ff @(posedge clock) begin
        if (fundamental_reset) begin
            pin_oe_q  <= '0;
            pin_out_q <= '0;
        end else begin
            pin_oe_q  <= gpio_out_mask | (serial_oe & secondary_mask);
            pin_out_q <= (level_q & ~secondary_mask) | (serial_out & secondary_mask);
        end
    end

    // Register answer: one cycle after the request is taken.
    always_ff @(posedge clock) begin
        if (srst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.ack   <= taken;
            rsp_q.rdata <= taken ? read_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_fund_clears_dir: assert property (@(posedge clock)
        fundamental_reset |=> (direction_q == 8'h00) && (level_q == 8'h00) && (pin_oe_q == 8'h00))
        else $error("direction not cleared by fundamental reset");

    chk_srst_keeps: assert property (@(posedge clock) disable iff (fundamental_reset)
        srst |=> (direction_q == $past(direction_q)) && (level_q == $past(level_q)))
        else $error("ordinary reset disturbed port storage");

    chk_upper_zero: assert property (@(posedge clock) disable iff (srst)
        (taken && !req.write && (hit_dir || hit_level)) |=> rsp_q.ack && rsp_q.rdata[15:8] == 8'h00)
        else $error("reserved upper byte read nonzero");

    chk_ignored_writes: assert property (@(posedge clock) disable iff (srst || fundamental_reset)
        ##1 ((($past(level_q) ^ level_q) & ~$past(gpio_out_mask)) == 8'h00))
        else $error("level of input or secondary pin changed");

    chk_output_write: assert property (@(posedge clock) disable iff (srst || fundamental_reset)
        (low_write && hit_level && !serial_ctl.enable && direction_q == 8'hFF)
        |=> level_q == $past(req.wdata[7:0]) ##1 pin_out_q == $past(req.wdata[7:0], 2))
        else $error("written level not driven on output pins");

    chk_dir_alias: assert property (@(posedge clock) disable iff (srst || fundamental_reset)
        (low_write && req.cfg_space && req.addr == `CFG_DIRECTION_OFFSET)
        |=> direction_q == $past(req.wdata[7:0]) ##1 (pin_oe_q & ~secondary_mask) == ($past(direction_q) & ~secondary_mask))
        else $error("configuration alias did not reach direction storage");

    chk_input_read: assert property (@(posedge clock) disable iff (srst || fundamental_reset)
        (taken && !req.write && hit_level && direction_q == 8'h00)
        |=> rsp_q.rdata[7:0] == $past(pin_sampled))
        else $error("input pin read did not return sampled level");

    chk_secondary_own: assert property (@(posedge clock) disable iff (srst || fundamental_reset)
        serial_ctl.enable |=> pin_oe_q[`SERIAL_CLOCK_PIN] == $past(serial_ctl.clock_oe)
                           && pin_oe_q[`SERIAL_DATA_PIN] == $past(serial_ctl.data_oe)
                           && pin_out_q[`SERIAL_CLOCK_PIN] == $past(serial_ctl.clock_out)
                           && pin_out_q[`SERIAL_DATA_PIN] == $past(serial_ctl.data_out))
        else $error("serial function did not own its pins");

    chk_output_readback: assert property (@(posedge clock) disable iff (srst || fundamental_reset)
        (taken && !req.write && hit_level && direction_q == 8'hFF && !serial_ctl.enable)
        |=> rsp_q.rdata[7:0] == $past(level_q))
        else $error("output pin read did not return driven level");

endmodule

/* dv/board_pins.sv */
// Board-side model of the eight external signals wired to the port's pins.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module board_pins (
    input  wire logic [7:0] pin_out_q,   // Level the port drives.
    input  wire logic [7:0] pin_oe_q,    // High where the port drives.
    input  wire logic [7:0] board_drive, // Level the board puts on an undriven pin.
    output logic      [7:0] pin_in       // Resolved wire level fed back to the port.
);
    // A driving port wins over the board's weak source, so a pin in output
    // mode reads back what the port drives and not the board level.
    assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & board_drive);
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the eight-pin port, driven through its register port.
`timescale 1ns/1ns
`include "gpio_port_regs.svh"
`define CMP(what, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end

////////////////////////////////////////////////////////////////////////////////
module tb_top import gpio_port_pkg::*; ;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary revision value.
    logic        clock = 1'b0;           // Free-running 125 MHz clock.
    logic        srst = 1'b1;            // Ordinary reset.
    logic        fundamental_reset = 1'b1; // Clears the sticky storage.
    reg_req_s    req = '0;               // Register request.
    reg_rsp_s    rsp_q;                  // Register answer.
    serial_ctl_s serial_ctl = '0;        // Serial controller stand-in.
    logic [7:0]  board_drive = 8'h5A;    // Board level on undriven pins.
    logic [7:0]  pin_in;                 // Resolved pin levels.
    logic [7:0]  pin_out_q;              // Port drive levels.
    logic [7:0]  pin_oe_q;               // Port drive enables.
    logic [7:0]  pin_sampled;            // Synchronised pin levels.
    int          miscompares = 0;        // Mismatch count.
    int          checks = 0;             // Comparison count.
    int          cycles = 0;             // Watchdog count.

    gpio_port #(.REVISION(REV)) DUT (.clock(clock), .srst(srst), .fundamental_reset(fundamental_reset),
        .req(req), .rsp_q(rsp_q), .serial_ctl(serial_ctl), .pin_in(pin_in), .pin_out_q(pin_out_q),
        .pin_oe_q(pin_oe_q), .pin_sampled(pin_sampled));
    board_pins board (.pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .board_drive(board_drive),
        .pin_in(pin_in));

    // Clock with an 8 ns period.
    always #4 clock = ~clock;

    // Watchdog: the sequence needs well under a thousand cycles.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One register access; the answer is looked at in the single cycle it stands.
    // The request is taken at the second edge, and the registered answer stands until the third.
    task automatic acc(input logic wr, input logic cfg, input logic [7:0] addr,
                       input logic [15:0] wd, input logic [1:0] be, output logic [15:0] rd);
        @(posedge clock);
        req <= '{valid: 1'b1, write: wr, cfg_space: cfg, addr: addr, wdata: wd, be: be};
        @(posedge clock);
        req.valid <= 1'b0;
        #1;
        `CMP("ack", 1'b1, rsp_q.ack)
        rd = rsp_q.rdata;
    endtask

    // Write with both byte lanes enabled; the high byte must be ignored.
    task automatic wr(input logic cfg, input logic [7:0] addr, input logic [15:0] wd);
        logic [15:0] unused;
        acc(1'b1, cfg, addr, wd, 2'h3, unused);
    endtask

    // Write with only the high byte lane enabled; nothing may be stored.
    task automatic wr_hi(input logic cfg, input logic [7:0] addr, input logic [15:0] wd);
        logic [15:0] unused;
        acc(1'b1, cfg, addr, wd, 2'h2, unused);
    endtask

    // Read and compare against an expected word.
    task automatic chk(input logic cfg, input logic [7:0] addr, input logic [15:0] exp, input string what);
        logic [15:0] got;
        acc(1'b0, cfg, addr, 16'h0000, 2'h3, got);
        `CMP(what, exp, got)
    endtask

    // Lets pin drivers update; the sampler needs four edges to follow a pin.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        fundamental_reset <= 1'b0;
        settle(6);
        chk(0, `WIN_DIRECTION_OFFSET, 16'h0000, "dir reset");
        `CMP("oe reset", 8'h00, pin_oe_q)
        `CMP("sampled", 8'h5A, pin_sampled)
        wr(0, `WIN_REVISION_OFFSET, 16'hFFFF);
        chk(0, `WIN_REVISION_OFFSET, {REV, 8'h00}, "revision");
        chk(0, 8'h44, 16'h0000, "unmapped");
        chk(0, `WIN_LEVEL_OFFSET, 16'h005A, "level in");
        chk(1, `CFG_LEVEL_OFFSET, 16'h005A, "cfg level");
        wr(0, `WIN_DIRECTION_OFFSET, 16'hFFFF);
        chk(1, `CFG_DIRECTION_OFFSET, 16'h00FF, "cfg dir");
        `CMP("oe out", 8'hFF, pin_oe_q)
        wr(0, `WIN_LEVEL_OFFSET, 16'h00C3);
        settle(1);
        `CMP("drive", 8'hC3, pin_out_q)
        chk(0, `WIN_LEVEL_OFFSET, 16'h00C3, "readback");
        // Upper nibble to input: its write is dropped, the board level shows.
        wr(1, `CFG_DIRECTION_OFFSET, 16'h000F);
        wr(0, `WIN_LEVEL_OFFSET, 16'h00FF);
        settle(6);
        chk(0, `WIN_LEVEL_OFFSET, 16'h005F, "mixed");
        wr(0, `WIN_DIRECTION_OFFSET, 16'h00FF);
        settle(1);
        `CMP("kept", 8'hCF, pin_out_q)
        // Serial function takes pins 4 and 5 although their direction says input.
        wr(0, `WIN_LEVEL_OFFSET, 16'h0030);
        wr(0, `WIN_DIRECTION_OFFSET, 16'h00CF);
        serial_ctl <= 5'b11101;
        wr(0, `WIN_LEVEL_OFFSET, 16'h0000);
        settle(6);
        `CMP("ser oe", 8'hFF, pin_oe_q)
        `CMP("ser out", 8'h10, pin_out_q)
        chk(0, `WIN_LEVEL_OFFSET, 16'h0010, "ser read");
        serial_ctl <= 5'b00000;
        wr(0, `WIN_DIRECTION_OFFSET, 16'h00FF);
        settle(1);
        `CMP("ser kept", 8'h30, pin_out_q)
        // An ordinary reset leaves storage and pins alone.
        srst <= 1'b1;
        settle(1);
        srst <= 1'b0;
        settle(1);
        `CMP("srst pins", 8'h30, pin_out_q)
        chk(0, `WIN_DIRECTION_OFFSET, 16'h00FF, "srst dir");
        fundamental_reset <= 1'b1;
        settle(1);
        fundamental_reset <= 1'b0;
        settle(2);
        `CMP("fundamental_reset oe", 8'h00, pin_oe_q)
        chk(0, `WIN_DIRECTION_OFFSET, 16'h0000, "fundamental_reset dir");
        wr_hi(0, `WIN_DIRECTION_OFFSET, 16'hFFFF);
        chk(0, `WIN_DIRECTION_OFFSET, 16'h0000, "hi lane dir");
        close_out();
    end
endmodule
